// >>> verilog/pdt_cfg.svh
// Constants for the phase drive timing block: offsets, fields, resets, times.
`ifndef PDT_CFG_SVH
`define PDT_CFG_SVH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define PDT_ADDR_W 8
`define PDT_OFS_RECT_CTRL 8'h07
`define PDT_OFS_DLY_CTRL 8'h0c
`define PDT_OFS_STATUS 8'h20
`define PDT_RST_RECT_CTRL 8'h00
`define PDT_RST_DLY_CTRL 8'h00

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PDT_BIT_ASYNC_RECT 3
`define PDT_BIT_SYNC_RECT 2
`define PDT_BIT_DLY_EN 4
`define PDT_DLY_CODE_HI 3
`define PDT_DLY_CODE_LO 0

// ---------------------------------------------------------------------------
// Timing, in nanoseconds at a 5 ns clock
// ---------------------------------------------------------------------------
`define PDT_CLK_NS 5
`define PDT_DEAD_NS 200
`define PDT_DEAD_CYC ((`PDT_DEAD_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_QUAL_NS 100
`define PDT_QUAL_CYC ((`PDT_QUAL_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_PD_TYP_NS 100
`define PDT_PD_TYP_CYC (`PDT_PD_TYP_NS / `PDT_CLK_NS)
`define PDT_PD_FAST_NS 50
`define PDT_PD_FAST_CYC (`PDT_PD_FAST_NS / `PDT_CLK_NS)
`define PDT_TGT_BASE_NS 200
`define PDT_TGT_STEP_NS 200
`define PDT_CNT_W 10

`endif

// >>> verilog/pdt_pkg.sv
// Types shared by the phase drive timing block.
package pdt_pkg;

  // One phase's gate pair.
  typedef struct packed {
    logic high;
    logic low;
  } pdt_gate_type;

  // Both demagnetization comparator levels for one phase.
  typedef struct packed {
    logic high_cmp;
    logic low_cmp;
  } pdt_demag_type;

  // Output sequencing state of one phase.
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_HIGH = 5'b00010,
    ST_LOW = 5'b00100,
    ST_DEAD = 5'b01000,
    ST_DEMAG = 5'b10000
  } pdt_state_type;

endpackage

// >>> verilog/pdt_delay_line.sv
// Per-phase delay of the two gate inputs by a variable cycle count.
`timescale 1ns/1ps
`include "pdt_cfg.svh"
module pdt_delay_line
  import pdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pdt_gate_type din,
  input wire logic [`PDT_CNT_W-1:0] delay_cyc,
  output pdt_gate_type dout
);

  // -------------------------------------------------------------------------
  // Pending edge hold
  // -------------------------------------------------------------------------
  // One pending input change is held; a change that arrives while one is
  // still waiting restarts the wait, trading fidelity for small area.
  pdt_gate_type held_ff;
  pdt_gate_type out_ff;
  logic [`PDT_CNT_W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      held_ff <= '0;
      cnt_ff <= '0;
    end else if (din != held_ff) begin
      held_ff <= din;
      cnt_ff <= delay_cyc;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Output follows the held value once the wait has run out.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff <= '0;
    end else if (din == held_ff && cnt_ff == '0) begin
      out_ff <= held_ff;
    end
  end

  assign dout = out_ff;

endmodule // pdt_delay_line

// >>> verilog/pdt_phase_seq.sv
// Per-phase dead time, controller dead time priority and demagnetization.
`timescale 1ns/1ps
`include "pdt_cfg.svh"
module pdt_phase_seq
  import pdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pdt_gate_type req,
  input wire pdt_demag_type demag,
  input wire logic demag_en,
  output pdt_gate_type gate,
  output pdt_state_type state
);

  localparam logic [`PDT_CNT_W-1:0] DEAD_CYC = `PDT_CNT_W'(`PDT_DEAD_CYC);
  localparam logic [`PDT_CNT_W-1:0] QUAL_CYC = `PDT_CNT_W'(`PDT_QUAL_CYC);

  pdt_state_type st_ff;
  pdt_state_type nxt_st;
  logic [`PDT_CNT_W-1:0] dead_ff;
  logic [`PDT_CNT_W-1:0] qual_ff;
  pdt_gate_type gate_ff;

  // -------------------------------------------------------------------------
  // State sequencing
  // -------------------------------------------------------------------------
  // A requested side is granted only after the dead count expires; while
  // the controller itself holds both inputs low the phase simply stays in
  // dead, so a longer controller gap wins over the shorter own gap.
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_OFF, ST_DEAD: begin
        if (dead_ff == '0 && req.high && !req.low) begin
          nxt_st = ST_HIGH;
        end else if (dead_ff == '0 && req.low && !req.high) begin
          nxt_st = ST_LOW;
        end else if (st_ff == ST_DEAD && dead_ff == '0 && demag_en &&
                     qual_ff >= QUAL_CYC) begin
          nxt_st = ST_DEMAG;
        end
      end
      ST_HIGH: begin
        if (!req.high || req.low) nxt_st = ST_DEAD;
      end
      ST_LOW: begin
        if (!req.low || req.high) nxt_st = ST_DEAD;
      end
      ST_DEMAG: begin
        if (!demag.low_cmp || req.high || req.low || !demag_en) begin
          nxt_st = ST_DEAD;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) st_ff <= ST_OFF;
    else st_ff <= nxt_st;
  end

  // Dead counter reloads whenever a conducting state is left.
  always_ff @(posedge clk) begin
    if (rst) begin
      dead_ff <= '0;
    end else if (nxt_st == ST_DEAD && st_ff != ST_DEAD) begin
      dead_ff <= DEAD_CYC;
    end else if (dead_ff != '0) begin
      dead_ff <= dead_ff - 1'b1;
    end
  end

  // Qualification starts only once the dead time has run out; the
  // comparator must then stay above threshold without a break.
  always_ff @(posedge clk) begin
    if (rst || st_ff != ST_DEAD || dead_ff != '0 || !demag.low_cmp ||
        demag.high_cmp) begin
      qual_ff <= '0;
    end else if (qual_ff < QUAL_CYC) begin
      qual_ff <= qual_ff + 1'b1;
    end
  end

  // Gates are registered; demag turns the low FET on, dead leaves both off.
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_ff <= '0;
    end else begin
      gate_ff.high <= (nxt_st == ST_HIGH);
      gate_ff.low <= (nxt_st == ST_LOW) || (nxt_st == ST_DEMAG);
    end
  end

  assign gate = gate_ff;
  assign state = st_ff;

endmodule // pdt_phase_seq

// >>> verilog/pdt_top.sv
// Top of the phase drive timing block: registers, compensation, phases.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "pdt_cfg.svh"

// Behaviour
// - Bit 4 of the delay control register enables compensation, reset off.
// - Target code 0 is zero, 1 is 0.4 us, each step adds 0.2 us.
// - When enabled, extra delay makes total delay equal the target where the target exceeds the inherent delay.
// - Demagnetization runs only with both rectification bits set.
// - Async rectification at bit 3, sync at bit 2, both reset off.
// - Demagnetization acts on commutation where a low side stays on.
// - Without demagnetization, dead time leaves the low FET off.
// - High and low comparators report sense voltage against threshold.
// - After dead time, qualified comparator turns the low FET on.
// - Low FET turns off once the comparator drops below threshold.
// - A short controller gap is stretched to the own dead time.
// - A longer controller gap is followed at the output.
// - Delay is typical for out-rising and in-falling, shorter otherwise.
module pdt_top
  import pdt_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [`PDT_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [2:0] HIGH_SIDE_INPUT,
  input wire logic [2:0] LOW_SIDE_INPUT,
  input wire logic [2:0] CURRENT_OUT,
  input wire logic [2:0] DEMAG_HIGH_COMPARATOR,
  input wire logic [2:0] DEMAG_LOW_COMPARATOR,
  output logic [2:0] PHASE_OUTPUT_HIGH,
  output logic [2:0] PHASE_OUTPUT_LOW,
  output logic [2:0] DEMAG_ACTIVE
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  // Target time in cycles; 0 for code 0, else base plus one step per code,
  // so code 1 lands on two steps and the top code on sixteen.
  function automatic logic [`PDT_CNT_W-1:0] target_cyc(
    input logic [3:0] code
  );
    int ns;
    ns = 0;
    if (code != 4'h0) begin
      ns = `PDT_TGT_BASE_NS + `PDT_TGT_STEP_NS * int'(code);
    end
    return `PDT_CNT_W'(ns / `PDT_CLK_NS);
  endfunction

  // Inherent delay of a transition, by current direction and edge.
  function automatic logic [`PDT_CNT_W-1:0] inherent_cyc(
    input logic cur_out,
    input logic high_rising
  );
    if (cur_out == high_rising) begin
      return `PDT_CNT_W'(`PDT_PD_TYP_CYC);
    end
    return `PDT_CNT_W'(`PDT_PD_FAST_CYC);
  endfunction

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  logic [7:0] rect_ctrl_ff;
  logic [7:0] dly_ctrl_ff;
  logic [7:0] rdata_ff;

  // Reserved bits of the delay register are read-only zero.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dly_ctrl_ff <= `PDT_RST_DLY_CTRL;
    end else if (WR && ADDR == `PDT_OFS_DLY_CTRL) begin
      dly_ctrl_ff <= {3'h0, WDATA[4:0]};
    end
  end

  // Whole byte is writable; only bits 3 and 2 steer this block.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rect_ctrl_ff <= `PDT_RST_RECT_CTRL;
    end else if (WR && ADDR == `PDT_OFS_RECT_CTRL) begin
      rect_ctrl_ff <= WDATA;
    end
  end

  logic demag_en;
  logic comp_en;
  logic [3:0] code;
  assign demag_en = rect_ctrl_ff[`PDT_BIT_ASYNC_RECT] &
                    rect_ctrl_ff[`PDT_BIT_SYNC_RECT];
  assign comp_en = dly_ctrl_ff[`PDT_BIT_DLY_EN];
  assign code = dly_ctrl_ff[`PDT_DLY_CODE_HI:`PDT_DLY_CODE_LO];

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  // Two stages on every pin; only the second stage feeds logic.
  logic [14:0] pin_s1_ff;
  logic [14:0] pin_s2_ff;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {HIGH_SIDE_INPUT, LOW_SIDE_INPUT, CURRENT_OUT,
                    DEMAG_HIGH_COMPARATOR, DEMAG_LOW_COMPARATOR};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic [2:0] hi_s;
  logic [2:0] lo_s;
  logic [2:0] cur_s;
  logic [2:0] ahs_s;
  logic [2:0] als_s;
  assign {hi_s, lo_s, cur_s, ahs_s, als_s} = pin_s2_ff;

  // Previous high input, to tell the edge direction.
  logic [2:0] hi_prev_ff;
  always_ff @(posedge CLOCK) begin
    if (RST) hi_prev_ff <= '0;
    else hi_prev_ff <= hi_s;
  end

  // -------------------------------------------------------------------------
  // Phases
  // -------------------------------------------------------------------------
  logic [2:0] out_hi_ff;
  logic [2:0] out_lo_ff;
  logic [2:0] demag_act_ff;
  logic [2:0] st_demag;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic [`PDT_CNT_W-1:0] tgt;
    logic [`PDT_CNT_W-1:0] inh;
    logic [`PDT_CNT_W-1:0] var_cyc;
    pdt_gate_type req_raw;
    pdt_gate_type req_dly;
    pdt_gate_type gate;
    pdt_demag_type cmp;
    pdt_state_type st;

    assign tgt = target_cyc(code);
    assign inh = inherent_cyc(cur_s[p], hi_s[p] & ~hi_prev_ff[p]);
    // The line always carries the inherent, direction dependent delay; with
    // compensation on, the variable part stretches it up to the target, so
    // both current directions end at the same total. A target below the
    // inherent delay cannot be met and adds nothing.
    assign var_cyc = (comp_en && tgt > inh) ? tgt : inh;
    assign req_raw = '{high: hi_s[p], low: lo_s[p]};
    assign cmp = '{high_cmp: ahs_s[p], low_cmp: als_s[p]};

    pdt_delay_line u_dly (
      .clk(CLOCK),
      .rst(RST),
      .din(req_raw),
      .delay_cyc(var_cyc),
      .dout(req_dly)
    );

    pdt_phase_seq u_seq (
      .clk(CLOCK),
      .rst(RST),
      .req(req_dly),
      .demag(cmp),
      .demag_en(demag_en),
      .gate(gate),
      .state(st)
    );

    // Registered out so every pin comes straight from a flip-flop.
    always_ff @(posedge CLOCK) begin
      if (RST) begin
        out_hi_ff[p] <= 1'b0;
        out_lo_ff[p] <= 1'b0;
      end else begin
        out_hi_ff[p] <= gate.high;
        out_lo_ff[p] <= gate.low;
      end
    end
    assign st_demag[p] = (st == ST_DEMAG);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) demag_act_ff <= '0;
    else demag_act_ff <= st_demag;
  end

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  // Unmapped reads return zero; data stand one cycle after the strobe.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_ff <= '0;
    end else if (RD) begin
      unique case (ADDR)
        `PDT_OFS_DLY_CTRL: rdata_ff <= dly_ctrl_ff;
        `PDT_OFS_RECT_CTRL: rdata_ff <= rect_ctrl_ff;
        `PDT_OFS_STATUS: rdata_ff <= {1'b0, demag_en, comp_en, 2'b00,
                                      demag_act_ff};
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign RDATA = rdata_ff;
  assign PHASE_OUTPUT_HIGH = out_hi_ff;
  assign PHASE_OUTPUT_LOW = out_lo_ff;
  assign DEMAG_ACTIVE = demag_act_ff;

endmodule // pdt_top

// >>> bench/pdt_top_props.sv
// Checker for the phase drive timing block, bound to its top module.
`timescale 1ns/1ps
module pdt_top_props (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [2:0] HIGH_SIDE_INPUT,
  input wire logic [2:0] DEMAG_LOW_COMPARATOR,
  input wire logic [2:0] PHASE_OUTPUT_HIGH,
  input wire logic [2:0] PHASE_OUTPUT_LOW,
  input wire logic [2:0] DEMAG_ACTIVE
);
  // -------------------------------------------------------------------
  // Shadow of the two rectification enables
  // -------------------------------------------------------------------
  logic [1:0] rect_ff;
  // Tracked from bus writes, since the checker cannot see the register.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rect_ff <= 2'h0;
    end else if (WR && ADDR == 8'h07) begin
      rect_ff <= WDATA[3:2];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_no_overlap: assert property ((PHASE_OUTPUT_HIGH & PHASE_OUTPUT_LOW) == 3'h0)
    else $error("high and low gates on together");
  a_dead_gap: assert property ($fell(PHASE_OUTPUT_HIGH[0]) |->
    !PHASE_OUTPUT_LOW[0] throughout (##38 1'b1))
    else $error("low gate on inside dead time");
  a_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_reset_quiet: assert property (disable iff (1'b0) RST |=>
    PHASE_OUTPUT_HIGH == 3'h0 && PHASE_OUTPUT_LOW == 3'h0 && RDATA == 8'h00)
    else $error("outputs not cleared by reset");
  a_demag_low: assert property (DEMAG_ACTIVE[0] |-> PHASE_OUTPUT_LOW[0])
    else $error("demag without low gate");
  a_demag_armed: assert property (|DEMAG_ACTIVE |-> rect_ff == 2'h3)
    else $error("demag while not armed");
  a_demag_qual: assert property ($rose(DEMAG_ACTIVE[0]) |->
    $past(DEMAG_LOW_COMPARATOR[0], 3) && $past(DEMAG_LOW_COMPARATOR[0], 8))
    else $error("demag without qualified comparator");
  a_demag_end: assert property ($fell(DEMAG_LOW_COMPARATOR[0]) &&
    DEMAG_ACTIVE[0] |-> ##[1:8] !DEMAG_ACTIVE[0])
    else $error("demag not ended by comparator");
  a_high_cause: assert property ($rose(PHASE_OUTPUT_HIGH[0]) |->
    $past(HIGH_SIDE_INPUT[0], 4))
    else $error("high gate without request");
  c_demag: cover property ($rose(DEMAG_ACTIVE[0]));
  c_read: cover property (RD ##1 RDATA != 8'h00);
  c_dead: cover property ($fell(PHASE_OUTPUT_HIGH[0]) ##[38:42]
    $rose(PHASE_OUTPUT_LOW[0]));
endmodule // pdt_top_props

bind pdt_top pdt_top_props u_props (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .HIGH_SIDE_INPUT(HIGH_SIDE_INPUT),
  .DEMAG_LOW_COMPARATOR(DEMAG_LOW_COMPARATOR),
  .PHASE_OUTPUT_HIGH(PHASE_OUTPUT_HIGH),
  .PHASE_OUTPUT_LOW(PHASE_OUTPUT_LOW), .DEMAG_ACTIVE(DEMAG_ACTIVE));

// >>> bench/pdt_mcu_model.sv
// Controller model that drives the six gate requests with its own gap.
`timescale 1ns/1ps
module pdt_mcu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] tgt_high,
  input wire logic [2:0] tgt_low,
  input wire logic [7:0] gap,
  output logic [2:0] high_out,
  output logic [2:0] low_out,
  output logic busy
);
  logic [7:0] cnt_ff;
  // Leaving sides drop at once; new sides rise after the gap, as a
  // controller that inserts its own dead time would do.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_out <= 3'h0;
      low_out <= 3'h0;
      busy <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (go && !busy) begin
      high_out <= high_out & tgt_high;
      low_out <= low_out & tgt_low;
      cnt_ff <= gap;
      busy <= 1'b1;
    end else if (busy && cnt_ff == 8'h00) begin
      high_out <= tgt_high;
      low_out <= tgt_low;
      busy <= 1'b0;
    end else if (busy) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule // pdt_mcu_model

// >>> bench/tb_phase_drive_timing_logic.sv
// Self-checking bench for the phase drive timing block.
`timescale 1ns/1ps
module tb_phase_drive_timing_logic;
  logic CLOCK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, go = 1'b0, busy;
  logic [7:0] ADDR = 8'h0, WDATA = 8'h0, gap = 8'h0, RDATA, g, d;
  logic [2:0] cur = 3'h0, dlc = 3'h0, dhc = 3'h0, th = 3'h0, tl = 3'h0;
  logic [2:0] hin, lin, poh, pol, dact;
  logic [7:0] rv [4] = '{8'h0c, 8'h04, 8'h08, 8'h0c};
  wire logic [8:0] obs = {dact, pol, poh};
  int n_fail = 0, n_checks = 0, n, nt, ns;
  integer seed = 32'h18f08aaa;
  always #2.5 CLOCK = ~CLOCK;
  pdt_top DUT (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .HIGH_SIDE_INPUT(hin),
    .LOW_SIDE_INPUT(lin), .CURRENT_OUT(cur), .DEMAG_HIGH_COMPARATOR(dhc),
    .DEMAG_LOW_COMPARATOR(dlc), .PHASE_OUTPUT_HIGH(poh),
    .PHASE_OUTPUT_LOW(pol), .DEMAG_ACTIVE(dact));
  pdt_mcu_model u_mcu (.clk(CLOCK), .rst(RST), .go(go), .tgt_high(th),
    .tgt_low(tl), .gap(gap), .high_out(hin), .low_out(lin), .busy(busy));
  // -------------------------------------------------------------------
  // Tasks and expectations
  // -------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", s, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
    v = RDATA;
  endtask
  task automatic cmd(input logic [2:0] h, input logic [2:0] l, input logic [7:0] q);
    th <= h;
    tl <= l;
    gap <= q;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    @(posedge CLOCK);
  endtask
  // Long limits mean a hang, so they end the run; short ones only observe.
  task automatic waitfor(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (obs[s] !== v && c < lim) begin
      @(posedge CLOCK);
      c++;
    end
    if (c >= lim && lim >= 2000) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic pulse(output int c);
    int k;
    cmd(3'h1, 3'h0, 8'h0);
    waitfor(0, 1'b1, 2000, c);
    cmd(3'h0, 3'h0, 8'h0);
    waitfor(0, 1'b0, 2000, k);
    repeat (60) @(posedge CLOCK);
  endtask
  // Total delay is the larger of target and inherent delay.
  function automatic int lat(int n0, int inh, int c);
    int t;
    t = (c == 0) ? 0 : 40 * (c + 1);
    return n0 - inh + ((t > inh) ? t : inh);
  endfunction
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    rd(8'h0c, g); chk("dly_rst", 8'h00, g);
    rd(8'h07, g); chk("rect_rst", 8'h00, g);
    repeat (8) begin
      d = $random(seed);
      wr(8'h0c, d); rd(8'h0c, g); chk("dly_reg", d & 8'h1f, g);
      wr(8'h07, d); rd(8'h07, g); chk("rect_reg", d & 8'h0c, g & 8'h0c);
      wr(8'h33, d); rd(8'h33, g); chk("unmapped", 8'h00, g);
    end
    // Inherent delay by direction, then every target code.
    wr(8'h07, 8'h00); wr(8'h0c, 8'h00);
    cur <= 3'h1; pulse(nt);
    wr(8'h0c, 8'h0f); pulse(n); chk("comp_off", nt, n);
    cur <= 3'h0; pulse(ns); chk("dir_delay", 10, nt - ns);
    for (int c = 0; c < 16; c++) begin
      wr(8'h0c, 8'h10 | c[7:0]);
      cur <= 3'h1; pulse(n); chk("comp_out", lat(nt, 20, c), n);
      cur <= 3'h0; pulse(n); chk("comp_in", lat(ns, 10, c), n);
    end
    wr(8'h0c, 8'h00);
    // Controller gap below, then above, the own dead time.
    cmd(3'h1, 3'h0, 8'h0); waitfor(0, 1'b1, 2000, n);
    cmd(3'h0, 3'h1, 8'h0); waitfor(0, 1'b0, 2000, n);
    waitfor(3, 1'b1, 2000, n); chk("own_dead", 1, n >= 39 && n <= 41);
    d = 8'd60 + ($random(seed) & 8'h1f);
    cmd(3'h1, 3'h0, d); waitfor(3, 1'b0, 2000, n);
    waitfor(0, 1'b1, 2000, n); chk("mcu_dead", 1, n + 12 >= d && n <= d + 12);
    cmd(3'h0, 3'h0, 8'h0); repeat (60) @(posedge CLOCK);
    // Commutation with a steady low side; only both enables arm demag.
    // The last pass is armed but its high comparator blocks qualification.
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, rv[i]);
      dhc <= (i == 3) ? 3'h1 : 3'h0;
      cmd(3'h1, 3'h2, 8'h0); waitfor(0, 1'b1, 2000, n);
      cmd(3'h4, 3'h2, 8'h0); waitfor(0, 1'b0, 2000, n);
      dlc <= 3'h1;
      waitfor(6, 1'b1, 300, n);
      @(posedge CLOCK);
      chk("demag_on", rv[i] == 8'h0c && i < 3, pol[0]);
      chk("demag_wait", 1, (rv[i] == 8'h0c && i < 3) ? n >= 58 && n < 300 :
        n == 300);
      dlc <= 3'h0; waitfor(6, 1'b0, 2000, n);
      repeat (2) @(posedge CLOCK);
      chk("demag_off", 0, pol[0]);
      cmd(3'h0, 3'h0, 8'h0); repeat (100) @(posedge CLOCK);
    end
    complete_run();
  end
endmodule // tb_phase_drive_timing_logic
